// [design/ccs_clock_ctrl.sv]
`timescale 1ns/100ps
module ccs_clock_ctrl #(
    parameter int INT_SETTLE_EDGES = 64
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire ccs_pkg::ccs_bus_req_t avs_req_i,
    output ccs_pkg::ccs_bus_rsp_t      avs_rsp_o,
    input  wire ccs_pkg::ccs_src_t     src_i,
    input  wire logic                  crystal_input_pin_i,
    input  wire logic                  crystal_output_pin_i,
    input  wire logic                  stop_exec_i,
    input  wire logic                  stop_release_i,
    output logic                       input_pin_port_mode_o,
    output logic                       output_pin_port_mode_o,
    output logic                       xtal_amp_enable_o,
    output logic                       ext_clock_input_enable_o,
    output logic                       int_osc_enable_o,
    output logic                       stop_mode_o,
    output logic [ccs_pkg::SEL_W-1:0]  osc_settle_time_select_o,
    output ccs_pkg::ccs_clk_t          clk_out_o
);
    import ccs_pkg::*;

    localparam logic [CNT_W-1:0] INT_SETTLE = CNT_W'(INT_SETTLE_EDGES);

    initial begin
        if (INT_SETTLE_EDGES < 1 || INT_SETTLE_EDGES > 65535) begin
            $error("ccs_clock_ctrl: INT_SETTLE_EDGES out of range");
        end
    end

    // control state
    logic             hs_pin_osc_enable_q;
    logic             ext_clock_select_q;
    logic             hs_clock_stop_q;
    logic             main_source_select_q;
    logic             peripheral_source_select_q;
    logic [DIV_W-1:0] cpu_div_q;
    logic             cpu_subsystem_select_q;
    logic             int_osc_stop_q;
    logic [SEL_W-1:0] settle_sel_q;
    ccs_pwr_t         pwr_q;

    // bus state
    logic              ack_q;
    logic              wait_q;
    logic [DATA_W-1:0] rdata_q;

    // synchronisers: src int, sub, xtal, input pin, output pin
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;

    // derived state
    ccs_pin_mode_t    pin_mode;
    logic             hs_run;
    logic             int_run;
    logic             hs_src;
    logic             int_src;
    logic             hs_prev_q;
    logic             int_prev_q;
    logic [CNT_W-1:0] hs_cnt_q;
    logic [CNT_W-1:0] int_cnt_q;
    logic             int_stable_q;
    logic             in_port_q;
    logic             out_port_q;
    logic             amp_en_q;
    logic             ext_en_q;
    logic             int_en_q;
    logic             main_clk;
    logic             main_cur;
    logic             periph_clk;
    logic             cpu_div_clk;
    logic             cpu_clk;
    logic             cpu_cur;
    logic             bus_req;

    function automatic logic wr_hit(input ccs_bus_req_t r, input logic ack,
                                    input logic [ADDR_W-1:0] ofs);
        wr_hit = r.write && ack && (r.address == ofs);
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
    endfunction

    always_comb begin
        if (!hs_pin_osc_enable_q) begin
            pin_mode = PIN_PORT;
        end else if (ext_clock_select_q) begin
            pin_mode = PIN_EXT;
        end else begin
            pin_mode = PIN_XTAL;
        end
    end

    // stop mode removes both high-speed sources
    assign hs_run  = !hs_clock_stop_q && (pwr_q == PWR_RUN) && (pin_mode != PIN_PORT);
    assign int_run = !int_osc_stop_q && (pwr_q == PWR_RUN);
    assign hs_src  = hs_run && ((pin_mode == PIN_EXT) ? sync2_q[4] : sync2_q[2]);
    assign int_src = int_run && sync2_q[0];
    assign bus_req = avs_req_i.read || avs_req_i.write;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {crystal_output_pin_i, crystal_input_pin_i, src_i.xtal,
                        src_i.sub, src_i.int_osc};
            sync2_q <= sync1_q;
        end
    end

    // avalon slave: waitrequest low one cycle after the request arrives
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q  <= 1'b0;
            wait_q <= 1'b1;
        end else if (bus_req && !ack_q) begin
            ack_q  <= 1'b1;
            wait_q <= 1'b0;
        end else begin
            ack_q  <= 1'b0;
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (avs_req_i.read && !ack_q) begin
            rdata_q <= '0;
            unique case (avs_req_i.address)
                OFS_OSC_PIN: begin
                    rdata_q[BIT_OSC_EN]  <= hs_pin_osc_enable_q;
                    rdata_q[BIT_EXT_SEL] <= ext_clock_select_q;
                end
                OFS_MAIN_OSC: begin
                    rdata_q[BIT_HS_STOP] <= hs_clock_stop_q;
                end
                OFS_CLK_MODE: begin
                    rdata_q[BIT_PERIPH_SEL] <= peripheral_source_select_q;
                    rdata_q[BIT_MAIN_SEL]   <= main_source_select_q;
                    rdata_q[BIT_HS_STAT]    <= main_cur;
                end
                OFS_CPU_CLK: begin
                    rdata_q[DIV_LSB +: DIV_W] <= cpu_div_q;
                    rdata_q[BIT_CSS]          <= cpu_subsystem_select_q;
                    rdata_q[BIT_SUB_STAT]     <= cpu_cur;
                end
                OFS_INT_OSC: begin
                    rdata_q[BIT_INT_STOP]   <= int_osc_stop_q;
                    rdata_q[BIT_INT_STABLE] <= int_stable_q;
                end
                OFS_SETTLE: begin
                    rdata_q[SEL_LSB +: SEL_W] <= settle_sel_q;
                    rdata_q[CNT_LSB +: CNT_W] <= hs_cnt_q;
                end
                OFS_PORT_IN: begin
                    rdata_q[BIT_PIN_IN]  <= in_port_q ? sync2_q[3] : 1'b0;
                    rdata_q[BIT_PIN_OUT] <= out_port_q ? sync2_q[4] : 1'b0;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end

    // register writes land on the edge where waitrequest is seen low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_pin_osc_enable_q <= 1'b0;
            ext_clock_select_q  <= 1'b0;
        end else if (wr_hit(avs_req_i, ack_q, OFS_OSC_PIN)) begin
            hs_pin_osc_enable_q <= avs_req_i.writedata[BIT_OSC_EN];
            ext_clock_select_q  <= avs_req_i.writedata[BIT_EXT_SEL];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_clock_stop_q <= HS_STOP_RST;
        end else if (wr_hit(avs_req_i, ack_q, OFS_MAIN_OSC)) begin
            hs_clock_stop_q <= avs_req_i.writedata[BIT_HS_STOP];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_source_select_q       <= 1'b0;
            peripheral_source_select_q <= 1'b0;
        end else if (wr_hit(avs_req_i, ack_q, OFS_CLK_MODE)) begin
            main_source_select_q       <= avs_req_i.writedata[BIT_MAIN_SEL];
            peripheral_source_select_q <= avs_req_i.writedata[BIT_PERIPH_SEL];
        end
    end

    // prohibited ratio codes leave the ratio unchanged
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_div_q              <= DIV_RST;
            cpu_subsystem_select_q <= 1'b0;
        end else if (wr_hit(avs_req_i, ack_q, OFS_CPU_CLK)) begin
            cpu_subsystem_select_q <= avs_req_i.writedata[BIT_CSS];
            if (avs_req_i.writedata[DIV_LSB +: DIV_W] <= DIV_MAX) begin
                cpu_div_q <= avs_req_i.writedata[DIV_LSB +: DIV_W];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_osc_stop_q <= 1'b0;
        end else if (wr_hit(avs_req_i, ack_q, OFS_INT_OSC)) begin
            int_osc_stop_q <= avs_req_i.writedata[BIT_INT_STOP];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_sel_q <= SEL_RST;
        end else if (wr_hit(avs_req_i, ack_q, OFS_SETTLE)) begin
            settle_sel_q <= avs_req_i.writedata[SEL_LSB +: SEL_W];
        end
    end

    // stop mode: release wins over a stop in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_q <= PWR_RUN;
        end else begin
            unique case (pwr_q)
                PWR_RUN: begin
                    if (stop_exec_i && !stop_release_i) begin
                        pwr_q <= PWR_STOP;
                    end
                end
                PWR_STOP: begin
                    if (stop_release_i) begin
                        pwr_q <= PWR_RUN;
                    end
                end
            endcase
        end
    end

    // settle counter: high-speed edges since start, cleared while stopped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_prev_q <= 1'b0;
            hs_cnt_q  <= '0;
        end else begin
            hs_prev_q <= hs_src;
            if (!hs_run) begin
                hs_cnt_q <= '0;
            end else if (hs_src && !hs_prev_q) begin
                hs_cnt_q <= sat_inc(hs_cnt_q);
            end
        end
    end

    // internal oscillator accuracy flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_prev_q   <= 1'b0;
            int_cnt_q    <= '0;
            int_stable_q <= 1'b0;
        end else begin
            int_prev_q <= int_src;
            if (!int_run) begin
                int_cnt_q    <= '0;
                int_stable_q <= 1'b0;
            end else if (int_src && !int_prev_q) begin
                int_cnt_q <= sat_inc(int_cnt_q);
                if (int_cnt_q >= INT_SETTLE - 16'h0001) begin
                    int_stable_q <= 1'b1;
                end
            end
        end
    end

    // pin and oscillator control outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_port_q  <= 1'b1;
            out_port_q <= 1'b1;
            amp_en_q   <= 1'b0;
            ext_en_q   <= 1'b0;
            int_en_q   <= 1'b1;
        end else begin
            in_port_q  <= (pin_mode != PIN_XTAL);
            out_port_q <= (pin_mode == PIN_PORT);
            amp_en_q   <= hs_run && (pin_mode == PIN_XTAL);
            ext_en_q   <= hs_run && (pin_mode == PIN_EXT);
            int_en_q   <= int_run;
        end
    end

    // main clock is high-speed only when both selects are set
    ccs_clk_mux u_main_mux (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .src0_i  (int_src),
        .src1_i  (hs_src),
        .sel_i   (main_source_select_q && peripheral_source_select_q),
        .clk_o   (main_clk),
        .cur_o   (main_cur)
    );

    ccs_clk_mux u_periph_mux (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .src0_i  (int_src),
        .src1_i  (hs_src),
        .sel_i   (main_source_select_q),
        .clk_o   (periph_clk),
        .cur_o   ()
    );

    ccs_clk_div #(
        .RATIO_W (DIV_W)
    ) u_cpu_div (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .clk_in_i (main_clk),
        .ratio_i  (cpu_div_q),
        .clk_o    (cpu_div_clk)
    );

    ccs_clk_mux u_cpu_mux (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .src0_i  (cpu_div_clk),
        .src1_i  (sync2_q[1]),
        .sel_i   (cpu_subsystem_select_q),
        .clk_o   (cpu_clk),
        .cur_o   (cpu_cur)
    );

    assign avs_rsp_o                = '{readdata: rdata_q, waitrequest: wait_q};
    assign input_pin_port_mode_o    = in_port_q;
    assign output_pin_port_mode_o   = out_port_q;
    assign xtal_amp_enable_o        = amp_en_q;
    assign ext_clock_input_enable_o = ext_en_q;
    assign int_osc_enable_o         = int_en_q;
    assign stop_mode_o              = pwr_q;
    assign osc_settle_time_select_o = settle_sel_q;
    assign clk_out_o                = '{main: main_clk, periph: periph_clk, cpu: cpu_clk};

endmodule

// [design/ccs_pkg.sv]
package ccs_pkg;

    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_OSC_PIN   = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_MAIN_OSC  = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CLK_MODE  = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CPU_CLK   = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_INT_OSC   = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_SETTLE    = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_PORT_IN   = 5'h18;

    // field positions
    localparam int BIT_OSC_EN      = 0;
    localparam int BIT_EXT_SEL     = 1;
    localparam int BIT_HS_STOP     = 0;
    localparam int BIT_PERIPH_SEL  = 0;
    localparam int BIT_MAIN_SEL    = 1;
    localparam int BIT_HS_STAT     = 2;
    localparam int DIV_LSB         = 0;
    localparam int DIV_W           = 3;
    localparam int BIT_CSS         = 3;
    localparam int BIT_SUB_STAT    = 4;
    localparam int BIT_INT_STOP    = 0;
    localparam int BIT_INT_STABLE  = 1;
    localparam int SEL_LSB         = 0;
    localparam int SEL_W           = 3;
    localparam int CNT_LSB         = 16;
    localparam int CNT_W           = 16;
    localparam int BIT_PIN_IN      = 0;
    localparam int BIT_PIN_OUT     = 1;

    // reset values and limits
    localparam logic             HS_STOP_RST = 1'b1;
    localparam logic [DIV_W-1:0] DIV_RST     = 3'h1;
    localparam logic [DIV_W-1:0] DIV_MAX     = 3'h4;
    localparam logic [SEL_W-1:0] SEL_RST     = 3'h7;
    localparam logic [CNT_W-1:0] CNT_MAX     = 16'hffff;

    // avalon-mm request and answer
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } ccs_bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic              waitrequest;
    } ccs_bus_rsp_t;

    // raw clock sources, sampled levels
    typedef struct packed {
        logic int_osc;
        logic xtal;
        logic sub;
    } ccs_src_t;

    // generated clocks
    typedef struct packed {
        logic main;
        logic periph;
        logic cpu;
    } ccs_clk_t;

    typedef enum logic [1:0] {
        PIN_PORT = 2'b00,
        PIN_XTAL = 2'b01,
        PIN_EXT  = 2'b10
    } ccs_pin_mode_t;

    typedef enum logic {
        PWR_RUN  = 1'b0,
        PWR_STOP = 1'b1
    } ccs_pwr_t;

endpackage

// [design/ccs_clk_mux.sv]
`timescale 1ns/100ps
// glitch-free two-way clock switch over sampled clock levels
module ccs_clk_mux (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic src0_i,
    input  wire logic src1_i,
    input  wire logic sel_i,
    output logic      clk_o,
    output logic      cur_o
);
    logic cur_q;
    logic armed_q;
    logic out_q;
    logic src;
    logic swap;

    assign src   = cur_q ? src1_i : src0_i;
    assign swap  = (sel_i != cur_q) && !out_q;
    assign clk_o = out_q;
    assign cur_o = cur_q;

    // change source only while the output is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_q <= 1'b0;
        end else if (swap) begin
            cur_q <= sel_i;
        end
    end

    // follow the new source only after seeing it low, so no runt pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
        end else if (swap) begin
            armed_q <= 1'b0;
        end else if (!armed_q && !src) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_q <= 1'b0;
        end else begin
            out_q <= (armed_q && !swap) ? src : 1'b0;
        end
    end
endmodule

// [design/ccs_clk_div.sv]
`timescale 1ns/100ps
// power-of-two divider; ratio changes take effect only at a low phase
module ccs_clk_div #(
    parameter int RATIO_W = 3
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               clk_in_i,
    input  wire logic [RATIO_W-1:0] ratio_i,
    output logic                    clk_o
);
    logic               prev_q;
    logic [7:0]         cnt_q;
    logic [RATIO_W-1:0] ratio_q;
    logic               out_q;
    logic               rise;
    logic               load;

    function automatic logic [7:0] half_m1(input logic [RATIO_W-1:0] r);
        half_m1 = (r == '0) ? 8'h00 : 8'((9'h1 << (r - 1'b1)) - 9'h1);
    endfunction

    initial begin
        if (RATIO_W < 1 || RATIO_W > 4) begin
            $error("ccs_clk_div: RATIO_W out of range");
        end
    end

    assign rise  = clk_in_i && !prev_q;
    assign load  = (ratio_i != ratio_q) && !out_q && !clk_in_i && (cnt_q == 8'h00);
    assign clk_o = out_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= clk_in_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ratio_q <= '0;
        end else if (load) begin
            ratio_q <= ratio_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            out_q <= 1'b0;
        end else if (load) begin
            cnt_q <= 8'h00;
            out_q <= 1'b0;
        end else if (ratio_q == '0) begin
            out_q <= clk_in_i;
        end else if (rise) begin
            if (cnt_q == half_m1(ratio_q)) begin
                cnt_q <= 8'h00;
                out_q <= !out_q;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

// [testbench/ccs_xtal_model.sv]
`timescale 1ns/100ps
module ccs_xtal_model (
    input  wire logic amp_en_i,
    input  wire logic ext_sel_i,
    input  wire logic port1_i,
    input  wire logic port2_i,
    output logic      xtal_o,
    output logic      pin1_o,
    output logic      pin2_o
);
    logic osc_q = 1'b0;
    // resonator or external source runs free
    always #35 osc_q = ~osc_q;
    // amplifier output only swings while enabled
    assign xtal_o = amp_en_i & osc_q;
    assign pin1_o = port1_i;
    assign pin2_o = ext_sel_i ? osc_q : port2_i;
endmodule

// [testbench/ccs_clock_ctrl_monitor.sv]
`timescale 1ns/100ps
module ccs_clock_ctrl_monitor import ccs_pkg::*; (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire ccs_pkg::ccs_bus_req_t avs_req_i,
    input wire ccs_pkg::ccs_bus_rsp_t avs_rsp_o,
    input wire logic                  stop_exec_i,
    input wire logic                  stop_release_i,
    input wire logic                  input_pin_port_mode_o,
    input wire logic                  output_pin_port_mode_o,
    input wire logic                  xtal_amp_enable_o,
    input wire logic                  ext_clock_input_enable_o,
    input wire logic                  int_osc_enable_o,
    input wire logic                  stop_mode_o
);
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_req;
        $rose(avs_req_i.read) || $rose(avs_req_i.write);
    endsequence
    sequence s_ack;
        avs_rsp_o.waitrequest ##1 !avs_rsp_o.waitrequest ##1 avs_rsp_o.waitrequest;
    endsequence
    a_bus_one_wait: assert property (s_req |-> s_ack)
        else $error("bus wait wrong");
    a_reset_state: assert property ($rose(rst_n_i) |-> input_pin_port_mode_o
        && output_pin_port_mode_o && int_osc_enable_o) else $error("reset state wrong");
    a_stop_entry: assert property (stop_exec_i && !stop_release_i |=> stop_mode_o)
        else $error("stop not entered");
    a_stop_release: assert property (stop_release_i |=> !stop_mode_o)
        else $error("stop not left");
    a_stop_halts: assert property (stop_mode_o ##1 stop_mode_o |-> !xtal_amp_enable_o
        && !ext_clock_input_enable_o && !int_osc_enable_o) else $error("source runs in stop");
    a_xtal_pins: assert property (xtal_amp_enable_o |-> !input_pin_port_mode_o
        && !output_pin_port_mode_o) else $error("pins in port mode");
    a_ext_pins: assert property (ext_clock_input_enable_o |-> input_pin_port_mode_o
        && !output_pin_port_mode_o) else $error("ext pin mode wrong");
    a_one_source: assert property (!(xtal_amp_enable_o && ext_clock_input_enable_o))
        else $error("two sources");
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_monitor u_mon (.clk_i, .rst_n_i, .avs_req_i, .avs_rsp_o,
    .stop_exec_i, .stop_release_i, .input_pin_port_mode_o, .output_pin_port_mode_o,
    .xtal_amp_enable_o, .ext_clock_input_enable_o, .int_osc_enable_o, .stop_mode_o);

// [testbench/ccs_clock_ctrl_tb.sv]
`timescale 1ns/100ps
module ccs_clock_ctrl_tb;
    import ccs_pkg::*;
    logic              clk_i, rst_n_i, iosc, sub_q, p1, p2, stp_x, stp_r, xt, pn1, pn2;
    logic              m1, m2, xon, ext, ion, stp;
    logic [SEL_W-1:0]  sel;
    logic [2:0]        c, old;
    logic [DATA_W-1:0] q;
    ccs_bus_req_t      req;
    ccs_bus_rsp_t      rsp;
    ccs_clk_t          ck;
    // source periods in clk_i cycles
    localparam int     IOSC_CYC = 16;
    localparam int     SUB_CYC  = 22;
    int                err_total, n_tests, cyc, i, seed;

    ccs_clock_ctrl #(.INT_SETTLE_EDGES(4)) uut (.clk_i, .rst_n_i, .avs_req_i(req),
        .avs_rsp_o(rsp), .src_i({iosc, xt, sub_q}), .crystal_input_pin_i(pn1),
        .crystal_output_pin_i(pn2), .stop_exec_i(stp_x), .stop_release_i(stp_r),
        .input_pin_port_mode_o(m1), .output_pin_port_mode_o(m2), .xtal_amp_enable_o(xon),
        .ext_clock_input_enable_o(ext), .int_osc_enable_o(ion), .stop_mode_o(stp),
        .osc_settle_time_select_o(sel), .clk_out_o(ck));
    ccs_xtal_model u_xtal (.amp_en_i(xon), .ext_sel_i(!m2), .port1_i(p1), .port2_i(p2),
        .xtal_o(xt), .pin1_o(pn1), .pin2_o(pn2));

    always #5 clk_i = ~clk_i;
    always #80 iosc = ~iosc;
    always #110 sub_q = ~sub_q;

    function automatic logic [2:0] div_exp(logic [2:0] o, logic [2:0] n);
        return (n > DIV_MAX) ? o : n;
    endfunction

    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req <= '{read: !w, write: w, address: a, writedata: d};
        do @(posedge clk_i); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req <= '{read: 1'b0, write: 1'b0, address: a, writedata: d};
        @(posedge clk_i);
    endtask

    // reads, retrying up to n times while a status settles
    task automatic poll(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input int n);
        bus(1'b0, a, '0);
        repeat (n) if (q !== e) bus(1'b0, a, '0);
        chk($sformatf("reg %h", a), e, q);
    endtask

    // period of generated clock k in clk_i cycles, after the ratio has settled
    task automatic chk_per(input string n, input int k, input int e);
        int t;
        repeat (2) @(posedge ck[k]);
        t = cyc;
        @(posedge ck[k]);
        chk(n, e, cyc - t);
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        {clk_i, rst_n_i, iosc, sub_q, p1, p2, stp_x, stp_r} = '0;
        req = '0;
        seed = 32'h3a88;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        poll(OFS_MAIN_OSC, 32'h1, 0);
        poll(OFS_CPU_CLK, 32'h1, 0);
        poll(OFS_SETTLE, 32'h7, 0);
        poll(5'h1c, 32'h0, 0);
        for (i = 0; i < 6; i++) begin
            {p2, p1} <= 2'($random(seed));
            repeat (4) @(posedge clk_i);
            poll(OFS_PORT_IN, {30'h0, p2, p1}, 0);
        end
        for (i = 1; i < 4; i += 2) begin
            bus(1'b1, OFS_OSC_PIN, 32'(i));
            bus(1'b1, OFS_MAIN_OSC, 32'h0);
            repeat (60) @(posedge clk_i);
            chk("mode", (i == 1) ? 32'h2 : 32'h9, {28'h0, m1, m2, xon, ext});
            bus(1'b0, OFS_SETTLE, '0);
            chk("settle", 32'h1, {31'h0, |q[31:16]});
            bus(1'b1, OFS_CLK_MODE, 32'h3);
            poll(OFS_CLK_MODE, 32'h7, 100);
            bus(1'b1, OFS_CLK_MODE, 32'h2);
            poll(OFS_CLK_MODE, 32'h2, 100);
            chk_per("main per", 2, IOSC_CYC);
            bus(1'b1, OFS_CLK_MODE, 32'h0);
            poll(OFS_CLK_MODE, 32'h0, 100);
            bus(1'b1, OFS_MAIN_OSC, 32'h1);
            repeat (2) @(posedge clk_i);
            chk("hs off", 32'h0, {30'h0, xon, ext});
        end
        chk_per("main per", 2, IOSC_CYC);
        chk_per("periph per", 1, IOSC_CYC);
        old = DIV_RST;
        for (i = 0; i < 16; i++) begin
            c = i[3] ? 3'($random(seed)) : i[2:0];
            bus(1'b1, OFS_CPU_CLK, {29'h0, c});
            old = div_exp(old, c);
            poll(OFS_CPU_CLK, {29'h0, old}, 0);
            chk_per("cpu per", 0, IOSC_CYC << old);
        end
        bus(1'b1, OFS_CPU_CLK, {28'h0, 1'b1, old});
        poll(OFS_CPU_CLK, {27'h0, 2'b11, old}, 100);
        chk_per("cpu sub per", 0, SUB_CYC);
        bus(1'b1, OFS_INT_OSC, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("int osc", 32'h0, {31'h0, ion});
        poll(OFS_INT_OSC, 32'h1, 0);
        bus(1'b1, OFS_INT_OSC, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("int osc", 32'h1, {31'h0, ion});
        poll(OFS_INT_OSC, 32'h2, 200);
        bus(1'b1, OFS_CPU_CLK, {29'h0, old});
        poll(OFS_CPU_CLK, {29'h0, old}, 100);
        c = 3'($random(seed));
        bus(1'b1, OFS_SETTLE, {29'h0, c});
        poll(OFS_SETTLE, {29'h0, c}, 0);
        chk("sel", {29'h0, c}, {29'h0, sel});
        stp_x <= 1'b1;
        @(posedge clk_i);
        stp_x <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("stop", 32'h8, {28'h0, stp, xon, ext, ion});
        stp_r <= 1'b1;
        @(posedge clk_i);
        stp_r <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("stop", 32'h0, {31'h0, stp});
        test_done();
    end
endmodule
